/* File: inc/subset_gate_pkg.sv */
// Contract
// RQ1 - long borrow-subtract: dif minus src minus carry
// RQ2 - zero tests set flags only, no store
// RQ3 - reserved float test leaves flags unpredictable
// RQ4 - each float type whole: D24 F22 G24 H32
// RQ5 - omitted float group gives reserved-instruction fault
// RQ6 - 10 char, 17 decimal string ops omittable singly
// RQ7 - omitted string op gives emulation exception
// RQ8 - both char moves always kernel, never omitted
// RQ9 - no compat mode: return into it faults
// RQ10 - register subgroups all or none
// RQ11 - timer subgroup omittable, irq enable bit kept
// RQ12 - clock, console, perf-monitor subgroups omittable
// RQ13 - 175 kernel ops always decode, 129 omittable
// RQ14 - kernel sizes byte to quad, no octa
// RQ15 - kernel class counts per category
// RQ16 - only string ops get emulation assist
// RQ17 - build parameters select present features
package subset_gate_pkg;
   // decode classification
   typedef enum logic [2:0] {
      CLS_KERNEL = 3'b000,     // executes normally
      CLS_FLOAT_OFF = 3'b001,  // omitted float group
      CLS_STRING_OFF = 3'b010, // omitted string op
      CLS_COMPAT_OFF = 3'b011, // return into missing compat mode
      CLS_PREG_OFF = 3'b100    // access to missing register
   } op_class_t;

   // float group indices into the enable vector
   localparam int FG_D = 0;
   localparam int FG_F = 1;
   localparam int FG_G = 2;
   localparam int FG_H = 3;
   localparam int FG_NONE = 4;
   localparam int STR_COUNT = 27;              // 10 char + 17 decimal
   localparam logic [4:0] STR_NONE = 5'h1f;    // not a string op

   // one-byte opcodes of interest
   localparam logic [7:0] OP_BORROW_SUB = 8'hd9;    // subtract_borrow_long
   localparam logic [7:0] OP_TEST_BYTE = 8'h95;
   localparam logic [7:0] OP_TEST_WORD = 8'hb5;
   localparam logic [7:0] OP_TEST_LONG = 8'hd5;
   localparam logic [7:0] OP_TEST_F = 8'h53;
   localparam logic [7:0] OP_TEST_D = 8'h73;
   localparam logic [7:0] OP_TEST_GH_EXT = 8'h53;   // with ext prefix: g
   localparam logic [7:0] OP_TEST_H_EXT = 8'h73;    // with ext prefix: h
   localparam logic [7:0] OP_CHAR_MOVE3 = 8'h28;    // kernel, never omitted
   localparam logic [7:0] OP_CHAR_MOVE5 = 8'h2c;
   localparam logic [7:0] OP_EXC_RETURN = 8'h02;
   localparam logic [7:0] OP_PREG_WRITE = 8'hda;
   localparam logic [7:0] OP_PREG_READ = 8'hdb;

   // processor register numbers
   localparam logic [7:0] PR_INTERVAL_CTRL = 8'h18;
   localparam logic [7:0] PR_NEXT_INTERVAL = 8'h19;
   localparam logic [7:0] PR_INTERVAL_COUNT = 8'h1a;
   localparam logic [7:0] PR_TIME_OF_YEAR = 8'h1b;
   localparam logic [7:0] PR_CON_RX_STATUS = 8'h20;
   localparam logic [7:0] PR_CON_TX_BUFFER = 8'h23;
   localparam logic [7:0] PR_PERF_ENABLE = 8'h3d;
   localparam int TIMER_IRQ_EN_BIT = 6;            // irq enable in control reg
   localparam logic TIMER_IRQ_EN_RESET = 1'b0;
endpackage

/* File: logic/flag_unit.sv */
`timescale 1ns/10ps
// borrow-subtract and zero-test arithmetic, purely combinational
module flag_unit
   import subset_gate_pkg::*;
(
   input wire logic [7:0] i_opcode,   // primary opcode byte
   input wire logic i_ext,            // extended-opcode prefix seen
   input wire logic [31:0] i_src,     // source / subtrahend
   input wire logic [31:0] i_dif,     // difference operand
   input wire logic i_carry,          // current carry flag
   output logic [31:0] o_result,      // borrow-subtract result
   output logic [3:0] o_nzvc,         // new flags
   output logic o_is_sub,             // opcode is borrow-subtract
   output logic o_is_test,            // opcode is a zero test
   output logic o_unpred              // reserved float operand tested
);
   logic [32:0] diff; // 33 bits to catch the borrow
   logic [14:0] exp_f; // float exponent field, per format

   always_comb begin
      diff = {1'b0, i_dif} - {1'b0, i_src} - {32'h0, i_carry}; // RQ1
      o_result = diff[31:0]; // RQ1
      o_is_sub = !i_ext && (i_opcode == OP_BORROW_SUB);
      o_is_test = 1'b0;
      o_unpred = 1'b0;
      o_nzvc = 4'h0;
      exp_f = 15'h0;
      if (o_is_sub) begin
         // signed overflow when operand signs differ and result flips
         o_nzvc = {diff[31], diff[31:0] == 32'h0,
                   (i_dif[31] != i_src[31]) && (diff[31] != i_dif[31]),
                   diff[32]};
      end else if (!i_ext) begin
         unique case (i_opcode)
            OP_TEST_BYTE: begin
               o_is_test = 1'b1; // RQ2
               o_nzvc = {i_src[7], i_src[7:0] == 8'h0, 2'b00}; // RQ14
            end
            OP_TEST_WORD: begin
               o_is_test = 1'b1; // RQ2
               o_nzvc = {i_src[15], i_src[15:0] == 16'h0, 2'b00}; // RQ14
            end
            OP_TEST_LONG: begin
               o_is_test = 1'b1; // RQ2
               o_nzvc = {i_src[31], i_src == 32'h0, 2'b00}; // RQ14
            end
            OP_TEST_F, OP_TEST_D: begin
               // f and d share the 8-bit exponent layout
               o_is_test = 1'b1; // RQ2
               exp_f = {7'h0, i_src[14:7]};
            end
            default: o_is_test = 1'b0;
         endcase
      end else begin
         unique case (i_opcode)
            OP_TEST_GH_EXT: begin
               o_is_test = 1'b1; // RQ2
               exp_f = {4'h0, i_src[14:4]};
            end
            OP_TEST_H_EXT: begin
               o_is_test = 1'b1; // RQ2
               exp_f = i_src[14:0];
            end
            default: o_is_test = 1'b0;
         endcase
      end
      if (o_is_test && (i_ext || i_opcode == OP_TEST_F || i_opcode == OP_TEST_D)) begin
         // zero exponent means zero, unless sign set: reserved operand
         o_nzvc = {i_src[15] && exp_f != 15'h0, exp_f == 15'h0, 2'b00};
         o_unpred = i_src[15] && exp_f == 15'h0; // RQ3
      end
   end
endmodule

/* File: logic/subset_instruction_gate.sv */
`timescale 1ns/10ps
// decode-stage gate: sorts each opcode into kernel or omitted feature,
// raises the matching fault, and runs the borrow-subtract and tests
module subset_instruction_gate
   import subset_gate_pkg::*;
#(
   parameter logic [3:0] P_FLOAT_EN = 4'hf,            // d,f,g,h present
   parameter logic [STR_COUNT-1:0] P_STRING_EN = '1,   // per string op
   parameter logic P_HAS_COMPAT = 1'b1,                // compat mode built
   parameter logic P_HAS_TIMER = 1'b1,                 // interval timer set
   parameter logic P_HAS_TOY = 1'b1,                   // time-of-year clock
   parameter logic P_HAS_CONSOLE = 1'b1,               // console quartet
   parameter logic P_HAS_PERF = 1'b1                   // perf monitor enable
)(
   input wire logic i_sys_clk,          // processor clock
   input wire logic i_sys_rst,          // sync reset, active high
   input wire logic i_valid,            // opcode presented this cycle
   input wire logic i_ext,              // extended-opcode prefix seen
   input wire logic [7:0] i_opcode,     // opcode byte after any prefix
   input wire logic [31:0] i_src,       // first source operand
   input wire logic [31:0] i_dif,       // difference operand
   input wire logic i_carry,            // current carry flag
   input wire logic i_ret_to_compat,    // return would enter compat mode
   input wire logic [7:0] i_preg_num,   // register number for moves
   output logic o_done,                 // one-cycle answer strobe
   output op_class_t o_class,           // classification
   output logic o_dispatch,             // execute normally
   output logic o_rsvd_instr_fault,     // reserved-instruction fault
   output logic o_emul_exc,             // subset-emulation exception
   output logic [4:0] o_emul_index,     // which string op to emulate
   output logic o_rsvd_oper_fault,      // reserved-operand fault
   output logic [31:0] o_result,        // value to store
   output logic o_result_we,            // store o_result to destination
   output logic [3:0] o_nzvc,           // new condition flags
   output logic o_cc_we,                // update flags
   output logic o_cc_unpred,            // flags are not defined
   output logic o_timer_irq_enable      // kernel timer irq enable bit
);
   // string opcodes in enable-vector order: 10 char then 17 decimal
   localparam logic [7:0] STR_OPS [STR_COUNT] = '{
      8'h29, 8'h2d, 8'h0b, 8'h3a, 8'h39, 8'h2e, 8'h2f, 8'h2a, 8'h3b, 8'h2b,
      8'h20, 8'h21, 8'hf8, 8'h35, 8'h37, 8'hf9, 8'h36, 8'h24, 8'h26, 8'h08,
      8'h09, 8'h27, 8'h38, 8'h34, 8'h25, 8'h22, 8'h23};

   logic [STR_COUNT-1:0] str_hit; // one-hot string match
   logic [4:0] str_idx;           // encoded string index
   int float_grp;                 // float group or none
   logic [31:0] alu_result;       // borrow-subtract result
   logic [3:0] alu_nzvc;          // arithmetic flags
   logic alu_is_sub;              // borrow-subtract opcode
   logic alu_is_test;             // zero-test opcode
   logic alu_unpred;              // reserved float operand
   logic preg_ok;                 // addressed register exists
   logic is_preg_op;              // move to/from processor register
   op_class_t next_class;         // classification this cycle

   // two-byte opcodes (prefix folded into ext) carry the g and h groups;
   // the ranges below are the whole group, so no single member can be lost
   // float group of an opcode; each type decodes whole or not at all
   function automatic int float_group(input logic ext, input logic [7:0] op);
      int g;
      g = FG_NONE;
      if (!ext) begin
         if (op >= 8'h40 && op <= 8'h55)
            g = FG_F; // RQ4
         else if (op == 8'h56 || (op >= 8'h60 && op <= 8'h76))
            g = FG_D; // RQ4
      end else begin
         if ((op >= 8'h40 && op <= 8'h55) || op == 8'h99 || op == 8'h33)
            g = FG_G; // RQ4
         else if (op == 8'h56 || (op >= 8'h60 && op <= 8'h76) || op == 8'h98
                  || op == 8'hf6 || op == 8'h32 || op == 8'hf7
                  || (op >= 8'h7c && op <= 8'h7f))
            g = FG_H; // RQ4
      end
      return g;
   endfunction

   // a flat compare array keeps the string match to one gate level per entry
   // compare against every string opcode at once
   generate
      for (genvar k = 0; k < STR_COUNT; k++) begin : g_str
         assign str_hit[k] = !i_ext && (i_opcode == STR_OPS[k]); // RQ6
      end
   endgenerate

   // encode the one-hot match; char moves are absent from the table
   always_comb begin
      str_idx = STR_NONE; // RQ8
      for (int k = 0; k < STR_COUNT; k++) begin
         if (str_hit[k])
            str_idx = 5'(k);
      end
   end

   // subgroup presence is one parameter per subgroup, so a build cannot
   // include half of one; unlisted numbers fall through as present
   // register presence: subgroups are all-or-none by construction
   always_comb begin
      unique case (i_preg_num)
         PR_INTERVAL_CTRL: preg_ok = 1'b1; // RQ11
         PR_NEXT_INTERVAL, PR_INTERVAL_COUNT: preg_ok = P_HAS_TIMER; // RQ10
         PR_TIME_OF_YEAR: preg_ok = P_HAS_TOY; // RQ12
         PR_PERF_ENABLE: preg_ok = P_HAS_PERF; // RQ12
         default: begin
            // console block spans four consecutive numbers
            if (i_preg_num >= PR_CON_RX_STATUS && i_preg_num <= PR_CON_TX_BUFFER)
               preg_ok = P_HAS_CONSOLE; // RQ12
            else
               preg_ok = 1'b1;
         end
      endcase
   end

   // shared arithmetic for the two computed opcode families
   flag_unit u_flag_unit (
      .i_opcode(i_opcode),
      .i_ext(i_ext),
      .i_src(i_src),
      .i_dif(i_dif),
      .i_carry(i_carry),
      .o_result(alu_result),
      .o_nzvc(alu_nzvc),
      .o_is_sub(alu_is_sub),
      .o_is_test(alu_is_test),
      .o_unpred(alu_unpred)
   );

   // priority follows the fault order: a float fault masks any string match,
   // though no opcode sits in two groups today; the order only matters if the
   // opcode tables are ever extended
   // classification; anything not omitted is kernel and dispatches
   always_comb begin
      float_grp = float_group(i_ext, i_opcode);
      is_preg_op = !i_ext && (i_opcode == OP_PREG_WRITE || i_opcode == OP_PREG_READ);
      next_class = CLS_KERNEL; // RQ13 RQ15
      if (float_grp != FG_NONE && !P_FLOAT_EN[float_grp[1:0]]) // RQ17
         next_class = CLS_FLOAT_OFF; // RQ5
      else if (str_idx != STR_NONE && !P_STRING_EN[str_idx])
         next_class = CLS_STRING_OFF; // RQ7
      else if (!i_ext && i_opcode == OP_EXC_RETURN && i_ret_to_compat && !P_HAS_COMPAT)
         next_class = CLS_COMPAT_OFF; // RQ9
      else if (is_preg_op && !preg_ok)
         next_class = CLS_PREG_OFF; // RQ10
   end

   // answer strobe and class, one cycle after the request
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_done <= 1'b0;
         o_class <= CLS_KERNEL;
      end else begin
         o_done <= i_valid;
         o_class <= i_valid ? next_class : CLS_KERNEL;
      end
   end

   // exactly one outcome pulse per answer, so fetch never sees a fault and
   // a dispatch together
   // fault and exception pulses; only string ops carry an index
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_dispatch <= 1'b0;
         o_rsvd_instr_fault <= 1'b0;
         o_emul_exc <= 1'b0;
         o_emul_index <= STR_NONE;
         o_rsvd_oper_fault <= 1'b0;
      end else begin
         o_dispatch <= i_valid && next_class == CLS_KERNEL; // RQ13
         o_rsvd_instr_fault <= i_valid && next_class == CLS_FLOAT_OFF; // RQ5
         // float and compat are left wholly to software, no assist
         o_emul_exc <= i_valid && next_class == CLS_STRING_OFF; // RQ16
         o_emul_index <= (i_valid && next_class == CLS_STRING_OFF) ? str_idx : STR_NONE;
         o_rsvd_oper_fault <= i_valid && (next_class == CLS_COMPAT_OFF
                                          || next_class == CLS_PREG_OFF); // RQ9
      end
   end

   // o_result and o_nzvc hold between writes; consumers qualify with the strobes
   // result and flag writeback for borrow-subtract, tests, interval-control register read
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_result <= 32'h0;
         o_result_we <= 1'b0;
         o_nzvc <= 4'h0;
         o_cc_we <= 1'b0;
         o_cc_unpred <= 1'b0;
      end else begin
         o_result_we <= 1'b0;
         o_cc_we <= 1'b0;
         o_cc_unpred <= 1'b0;
         if (i_valid && next_class == CLS_KERNEL) begin
            if (alu_is_sub) begin
               o_result <= alu_result; // RQ1
               o_result_we <= 1'b1; // RQ1
               o_nzvc <= alu_nzvc;
               o_cc_we <= 1'b1;
            end else if (alu_is_test) begin
               // tests never store, only flags move
               o_nzvc <= alu_nzvc; // RQ2
               o_cc_we <= 1'b1; // RQ2
               o_cc_unpred <= alu_unpred; // RQ3
            end else if (!i_ext && i_opcode == OP_PREG_READ
                         && i_preg_num == PR_INTERVAL_CTRL) begin
               // only the kernel enable bit is visible when timer absent
               o_result <= 32'(o_timer_irq_enable) << TIMER_IRQ_EN_BIT;
               o_result_we <= 1'b1;
            end
         end
      end
   end

   // only the enable bit is kept here; the counting registers live with
   // the timer itself and vanish as a group when it is left out
   // timer irq enable exists on every build, with or without the timer
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst)
         o_timer_irq_enable <= TIMER_IRQ_EN_RESET;
      else if (i_valid && !i_ext && i_opcode == OP_PREG_WRITE
               && i_preg_num == PR_INTERVAL_CTRL)
         o_timer_irq_enable <= i_src[TIMER_IRQ_EN_BIT]; // RQ11
   end
endmodule

/* File: test/subset_gate_chk.sv */
`timescale 1ns/10ps
// watches each decode answer against the request one edge earlier
module subset_gate_chk
   import subset_gate_pkg::*;
#(
   parameter logic [3:0] P_FLOAT_EN = 4'hf, // float groups built
   parameter logic P_HAS_COMPAT = 1'b1      // compat mode built
)(
   input wire logic i_sys_clk,           // clock
   input wire logic i_sys_rst,           // sync reset
   input wire logic i_valid,             // request
   input wire logic i_ext,               // prefix seen
   input wire logic [7:0] i_opcode,      // opcode
   input wire logic [31:0] i_src,        // source
   input wire logic [31:0] i_dif,        // difference
   input wire logic i_carry,             // carry in
   input wire logic i_ret_to_compat,     // return to compat
   input wire logic o_done,              // answer strobe
   input wire op_class_t o_class,        // class
   input wire logic o_dispatch,          // execute
   input wire logic o_rsvd_instr_fault,  // float fault
   input wire logic o_emul_exc,          // emulation
   input wire logic [4:0] o_emul_index,  // string index
   input wire logic o_rsvd_oper_fault,   // operand fault
   input wire logic [31:0] o_result,     // stored value
   input wire logic o_result_we,         // store strobe
   input wire logic [3:0] o_nzvc,        // flags
   input wire logic o_cc_we              // flag strobe
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);

   // a request carrying a one-byte opcode
   sequence s_op(logic [7:0] op);
      i_valid && !i_ext && i_opcode == op;
   endsequence

   answer_due_a: assert property (i_valid |=> o_done) else $error("no answer");
   idle_quiet_a: assert property (!i_valid |=> !o_done && !o_dispatch)
      else $error("stray answer");
   single_out_a: assert property (o_done |-> $onehot({o_dispatch, o_rsvd_instr_fault,
      o_emul_exc, o_rsvd_oper_fault})) else $error("outcome not single");
   borrow_sub_a: assert property (s_op(OP_BORROW_SUB) |=> o_result_we &&
      o_result == $past(i_dif) - $past(i_src) - $past(i_carry)) else $error("bad borrow sub");
   test_store_a: assert property (i_valid && !i_ext && (i_opcode == OP_TEST_BYTE ||
      i_opcode == OP_TEST_WORD || i_opcode == OP_TEST_LONG) |=> o_cc_we && !o_result_we)
      else $error("test stored");
   byte_zero_a: assert property (s_op(OP_TEST_BYTE) |=>
      o_nzvc[2] == ($past(i_src[7:0]) == 8'h00) && o_nzvc[3] == $past(i_src[7]))
      else $error("byte test flags");
   char_move_a: assert property (i_valid && !i_ext && (i_opcode == OP_CHAR_MOVE3 ||
      i_opcode == OP_CHAR_MOVE5) |=> o_dispatch && o_class == CLS_KERNEL)
      else $error("char move not kernel");
   float_off_a: assert property (s_op(OP_TEST_F) |=>
      o_rsvd_instr_fault == !P_FLOAT_EN[FG_F]) else $error("float group fault");
   emul_class_a: assert property (o_emul_exc |-> o_class == CLS_STRING_OFF &&
      o_emul_index < 5'd27) else $error("emulation class");
   compat_off_a: assert property (s_op(OP_EXC_RETURN) ##0 i_ret_to_compat |=>
      o_rsvd_oper_fault == !P_HAS_COMPAT) else $error("compat return");
endmodule

bind subset_instruction_gate subset_gate_chk #(.P_FLOAT_EN(P_FLOAT_EN),
   .P_HAS_COMPAT(P_HAS_COMPAT)) u_subset_gate_chk (.i_sys_clk(i_sys_clk),
   .i_sys_rst(i_sys_rst), .i_valid(i_valid), .i_ext(i_ext), .i_opcode(i_opcode),
   .i_src(i_src), .i_dif(i_dif), .i_carry(i_carry), .i_ret_to_compat(i_ret_to_compat),
   .o_done(o_done), .o_class(o_class), .o_dispatch(o_dispatch),
   .o_rsvd_instr_fault(o_rsvd_instr_fault), .o_emul_exc(o_emul_exc),
   .o_emul_index(o_emul_index), .o_rsvd_oper_fault(o_rsvd_oper_fault),
   .o_result(o_result), .o_result_we(o_result_we), .o_nzvc(o_nzvc), .o_cc_we(o_cc_we));

/* File: test/fetch_model.sv */
`timescale 1ns/10ps
// fetch side: hands one decoded opcode per request to the gate
module fetch_model (
   input wire logic i_sys_clk,  // processor clock
   output logic o_valid,        // request strobe
   output logic o_ext,          // prefix seen
   output logic [7:0] o_opcode, // opcode byte
   output logic [31:0] o_src,   // source operand
   output logic [31:0] o_dif,   // difference operand
   output logic o_carry,        // carry flag
   output logic o_compat,       // return enters compat
   output logic [7:0] o_preg    // register number
);
   // idle until the first request
   initial {o_valid, o_ext, o_opcode, o_src, o_dif, o_carry, o_compat, o_preg} = '0;

   // one request, taken at the edge after it is raised
   task automatic issue(input logic e, input logic [7:0] op, input logic [31:0] s,
      input logic [31:0] d, input logic c, input logic p, input logic [7:0] r);
      @(posedge i_sys_clk);
      o_valid <= 1'b1;
      o_ext <= e;
      o_opcode <= op;
      o_src <= s;
      o_dif <= d;
      o_carry <= c;
      o_compat <= p;
      o_preg <= r;
      @(posedge i_sys_clk);
      o_valid <= 1'b0;
      // operands flip once released so a stale value never passes for valid
      o_src <= ~s;
      o_dif <= ~d;
   endtask
endmodule

/* File: test/subset_instruction_gate_bench.sv */
`timescale 1ns/10ps
// self-checking bench for the subset decode gate
module subset_instruction_gate_bench;
   import subset_gate_pkg::*;
   localparam logic [3:0] FLT = 4'hd;          // f group left out
   localparam logic [26:0] STR = ~27'h2000080; // string ops 7 and 25 out
   localparam logic [4:0] OK = 5'h18;          // done and dispatch
   localparam logic [4:0] FI = 5'h14;          // done and float fault
   localparam logic [4:0] RO = 5'h11;          // done and operand fault
   logic i_sys_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic vld, ext, car, cpt, o_done, o_dispatch, o_rsvd_instr_fault, o_emul_exc;
   logic o_rsvd_oper_fault, o_result_we, o_cc_we, o_cc_unpred, o_timer_irq_enable;
   logic [7:0] opc, prn;
   logic [31:0] src, dif, o_result;
   logic [4:0] o_emul_index;
   logic [3:0] o_nzvc;
   op_class_t o_class;
   int n_fail = 0;
   int checks_done = 0;

   always #5 i_sys_clk = ~i_sys_clk;

   fetch_model u_fetch_model (.i_sys_clk(i_sys_clk), .o_valid(vld), .o_ext(ext),
      .o_opcode(opc), .o_src(src), .o_dif(dif), .o_carry(car), .o_compat(cpt), .o_preg(prn));

   subset_instruction_gate #(.P_FLOAT_EN(FLT), .P_STRING_EN(STR), .P_HAS_COMPAT(1'b0),
      .P_HAS_CONSOLE(1'b0)) u_subset_instruction_gate (.i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst), .i_valid(vld), .i_ext(ext), .i_opcode(opc), .i_src(src),
      .i_dif(dif), .i_carry(car), .i_ret_to_compat(cpt), .i_preg_num(prn),
      .o_done(o_done), .o_class(o_class), .o_dispatch(o_dispatch),
      .o_rsvd_instr_fault(o_rsvd_instr_fault), .o_emul_exc(o_emul_exc),
      .o_emul_index(o_emul_index), .o_rsvd_oper_fault(o_rsvd_oper_fault),
      .o_result(o_result), .o_result_we(o_result_we), .o_nzvc(o_nzvc), .o_cc_we(o_cc_we),
      .o_cc_unpred(o_cc_unpred), .o_timer_irq_enable(o_timer_irq_enable));

   // strobes and class of the latest answer
   function automatic logic [7:0] answer();
      return {o_done, o_dispatch, o_rsvd_instr_fault, o_emul_exc, o_rsvd_oper_fault, o_class};
   endfunction

   task automatic compare(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // request, then look once the answer edge has settled
   task automatic send(input logic e, input logic [7:0] op, input logic [31:0] s,
      input logic [31:0] d, input logic c, input logic p, input logic [7:0] r);
      u_fetch_model.issue(e, op, s, d, c, p, r);
      #1;
   endtask

   task automatic t_borrow;
      send(1'b0, OP_BORROW_SUB, 32'h1, 32'h5, 1'b1, 1'b0, 8'h00);
      compare({o_result, o_result_we, o_cc_we, o_nzvc}, {32'h3, 6'h30});
      // zero minus zero minus carry wraps and borrows
      send(1'b0, OP_BORROW_SUB, 32'h0, 32'h0, 1'b1, 1'b0, 8'h00);
      compare({o_result, o_nzvc}, {32'hffffffff, 4'h9});
   endtask

   task automatic t_tests;
      logic [7:0] ops[4] = '{OP_TEST_BYTE, OP_TEST_WORD, OP_TEST_LONG, OP_TEST_LONG};
      logic [31:0] vals[4] = '{32'h80, 32'h10000, 32'h80000000, 32'h1};
      logic [3:0] fl[4] = '{4'h8, 4'h4, 4'h8, 4'h0};
      for (int k = 0; k < 4; k++) begin
         send(1'b0, ops[k], vals[k], 32'h0, 1'b1, 1'b0, 8'h00);
         compare({o_cc_we, o_result_we, o_nzvc}, {2'b10, fl[k]});
      end
      send(1'b0, OP_TEST_D, 32'h4080, 32'h0, 1'b1, 1'b0, 8'h00);
      compare({o_cc_we, o_cc_unpred, o_result_we, o_nzvc}, 7'h40);
      // reserved operand: flags left unjudged
      send(1'b0, OP_TEST_D, 32'h8000, 32'h0, 1'b0, 1'b0, 8'h00);
      compare({o_cc_we, o_cc_unpred, o_result_we}, 3'b110);
   endtask

   task automatic t_floats;
      logic ex[6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      logic [7:0] ops[6] = '{8'h53, 8'h73, 8'h53, 8'h73, 8'h42, 8'h42};
      int grp[6] = '{FG_F, FG_D, FG_G, FG_H, FG_F, FG_G};
      for (int k = 0; k < 6; k++) begin
         send(ex[k], ops[k], 32'h4080, 32'h0, 1'b0, 1'b0, 8'h00);
         compare(answer(), FLT[grp[k]] ? {OK, CLS_KERNEL} : {FI, CLS_FLOAT_OFF});
      end
   endtask

   task automatic t_strings;
      logic [7:0] ops[7] = '{8'h2a, 8'h22, 8'h29, 8'h23, 8'h08, 8'h28, 8'h2c};
      logic [4:0] idx[7] = '{5'd7, 5'd25, 5'd0, 5'd26, 5'd19, 5'h1f, 5'h1f};
      logic en;
      for (int k = 0; k < 7; k++) begin
         en = (idx[k] == 5'h1f) ? 1'b1 : STR[idx[k]];
         send(1'b0, ops[k], 32'h0, 32'h0, 1'b0, 1'b0, 8'h00);
         compare({answer(), o_emul_index}, en ? {OK, CLS_KERNEL, 5'h1f} :
            {5'h12, CLS_STRING_OFF, idx[k]});
      end
   endtask

   task automatic t_compat_pregs;
      send(1'b0, OP_EXC_RETURN, 32'h0, 32'h0, 1'b0, 1'b1, 8'h00);
      compare(answer(), {RO, CLS_COMPAT_OFF});
      send(1'b0, OP_EXC_RETURN, 32'h0, 32'h0, 1'b0, 1'b0, 8'h00);
      compare(answer(), {OK, CLS_KERNEL});
      send(1'b0, OP_PREG_READ, 32'h0, 32'h0, 1'b0, 1'b0, PR_CON_RX_STATUS);
      compare(answer(), {RO, CLS_PREG_OFF});
      send(1'b0, OP_PREG_WRITE, 32'h0, 32'h0, 1'b0, 1'b0, PR_CON_TX_BUFFER);
      compare(answer(), {RO, CLS_PREG_OFF});
      send(1'b0, OP_PREG_READ, 32'h0, 32'h0, 1'b0, 1'b0, PR_TIME_OF_YEAR);
      compare(answer(), {OK, CLS_KERNEL});
      send(1'b0, OP_PREG_WRITE, 32'h40, 32'h0, 1'b0, 1'b0, PR_INTERVAL_CTRL);
      compare({answer(), o_timer_irq_enable}, {OK, CLS_KERNEL, 1'b1});
      send(1'b0, OP_PREG_READ, 32'h0, 32'h0, 1'b0, 1'b0, PR_INTERVAL_CTRL);
      compare({answer(), o_result, o_result_we}, {OK, CLS_KERNEL, 32'h40, 1'b1});
      send(1'b0, OP_PREG_READ, 32'h0, 32'h0, 1'b0, 1'b0, PR_PERF_ENABLE);
      compare(answer(), {OK, CLS_KERNEL});
   endtask

   task automatic conclude;
      if (n_fail == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (4) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_sys_clk);
      #1;
      compare({o_class, o_emul_index, o_nzvc, o_timer_irq_enable, o_done}, 14'h07c0);
      t_borrow();
      t_tests();
      t_floats();
      t_strings();
      t_compat_pregs();
      conclude();
   end

   // watchdog: the run needs well under a hundred cycles
   initial begin
      repeat (2000) @(posedge i_sys_clk);
      n_fail++;
      conclude();
   end
endmodule
